/* File: common/ccb_defs.vh */
// constants for the clock conditioner configuration bank
`ifndef CCB_DEFS_VH
`define CCB_DEFS_VH

// word length and address field
`define CCB_WORD_BITS     32
`define CCB_ADDR_MSB      3
`define CCB_DATA_LSB      4

// serial clock rises per valid frame, and counter ceiling
`define CCB_FRAME_CNT     6'h20
`define CCB_CNT_MAX       6'h3F

// word addresses
`define CCB_ADDR_CH0      4'h0
`define CCB_ADDR_CH4      4'h4
`define CCB_ADDR_RESET    4'h7
`define CCB_ADDR_TUNE     4'hA
`define CCB_ADDR_REFIN    4'hB
`define CCB_ADDR_LOOP1    4'hC
`define CCB_ADDR_GLOBAL   4'hD
`define CCB_ADDR_LOOP2R   4'hE
`define CCB_ADDR_LOOP2N   4'hF

// reset request bit in the reset word
`define CCB_RESET_BIT     4

// channel word fields
`define CCB_CH_SWING      23
`define CCB_CH_BST_MSB    22
`define CCB_CH_BST_LSB    21
`define CCB_CH_AST_MSB    20
`define CCB_CH_AST_LSB    19
`define CCB_CH_EN         16

// tuning word
`define CCB_TUNE_WAIT     29

// reference input word
`define CCB_REF1_BUF      11
`define CCB_REF0_BUF      10
`define CCB_LOS_TO_MSB    9
`define CCB_LOS_TO_LSB    8
`define CCB_LOS_TY_MSB    7
`define CCB_LOS_TY_LSB    6
`define CCB_SEL_MSB       5
`define CCB_SEL_LSB       4

// first loop word
`define CCB_L1_POL        31
`define CCB_L1_GAIN_MSB   30
`define CCB_L1_GAIN_LSB   28
`define CCB_L1_R_MSB      27
`define CCB_L1_R_LSB      16
`define CCB_L1_N_MSB      15
`define CCB_L1_N_LSB      4

// global word
`define CCB_G_XTAL        21
`define CCB_G_OSCBUF      20
`define CCB_G_ALLEN       18
`define CCB_G_PDN         17
`define CCB_G_DOUBLER     16
`define CCB_G_HZ2         15
`define CCB_G_HZ1         14

// second loop words
`define CCB_OSCF_MSB      28
`define CCB_OSCF_LSB      21
`define CCB_LDSEL_MSB     20
`define CCB_LDSEL_LSB     16
`define CCB_L2_R_MSB      15
`define CCB_L2_R_LSB      4
`define CCB_L2_GAIN_MSB   27
`define CCB_L2_GAIN_LSB   26
`define CCB_VDIV_MSB      25
`define CCB_VDIV_LSB      22
`define CCB_L2_N_MSB      21
`define CCB_L2_N_LSB      4

// default field values
`define CCB_DEF_SWING     1'b0
`define CCB_DEF_BST       2'h0
`define CCB_DEF_AST       2'h1
`define CCB_DEF_EN        1'b0
`define CCB_DEF_EN_CH2    1'b1
`define CCB_DEF_TUNE      1'b1
`define CCB_DEF_BUF       1'b1
`define CCB_DEF_LOS_TO    2'h1
`define CCB_DEF_LOS_TY    2'h3
`define CCB_DEF_SEL       2'h0
`define CCB_DEF_L1_POL    1'b1
`define CCB_DEF_L1_GAIN   3'h6
`define CCB_DEF_DIV12     12'h001
`define CCB_DEF_OFF       1'b0
`define CCB_DEF_ALLEN     1'b1
`define CCB_DEF_OSCF      8'hC8
`define CCB_DEF_LDSEL     5'h1F
`define CCB_DEF_L2_GAIN   2'h2
`define CCB_DEF_VDIV      4'h2
`define CCB_DEF_L2_N      18'h00001

`endif

/* File: rtl/ccb_config_bank.v */
// serially loaded configuration register bank of the clock conditioner
`timescale 1ns/10ps
`default_nettype none
`include "ccb_defs.vh"

module ccb_config_bank
#(
	parameter NUM_CH = 5
)
(
	input  wire              sys_clk,
	input  wire              rst,
	input  wire              serClk,
	input  wire              serData,
	input  wire              serLatch,
	input  wire              globalOutputEnablePin,
	output reg  [NUM_CH-1:0] channelSwingLevel,
	output reg  [NUM_CH-1:0] channelEnable,
	output wire [NUM_CH-1:0] channelActive,
	output reg  [NUM_CH*2-1:0] secondOutputState,
	output reg  [NUM_CH*2-1:0] firstOutputState,
	output reg               tuningWaitForLock,
	output reg               refOneBufferType,
	output reg               refZeroBufferType,
	output reg  [1:0]        signalLossTimeout,
	output reg  [1:0]        signalLossOutputType,
	output reg  [1:0]        referenceSourceSelect,
	output reg               firstLoopPumpPolarity,
	output reg  [2:0]        firstLoopPumpGain,
	output reg  [11:0]       firstLoopRefDivider,
	output reg  [11:0]       firstLoopFbDivider,
	output reg               referenceDoublerEnable,
	output reg               crystalSupportEnable,
	output reg               oscOutputBufferEnable,
	output reg               allOutputsEnable,
	output reg               powerDown,
	output reg               secondPumpHighZ,
	output reg               firstPumpHighZ,
	output reg  [7:0]        oscInputFrequency,
	output reg  [4:0]        lockDetectSelect,
	output reg  [11:0]       secondLoopRefDivider,
	output reg  [17:0]       secondLoopFbDivider,
	output reg  [1:0]        secondLoopPumpGain,
	output reg  [3:0]        oscOutputDivider,
	output reg               calibrationStart
);

	//----------------------------------------------------------------
	// pin synchronisers and edge detection
	//----------------------------------------------------------------
	reg  [1:0] clkSync_q;
	reg  [1:0] datSync_q;
	reg  [1:0] latSync_q;
	reg  [1:0] goeSync_q;
	reg        clkPrev_q;
	reg        latPrev_q;

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			clkSync_q <= 2'h0;
			datSync_q <= 2'h0;
			// latch idles high: no false rise after reset
			latSync_q <= 2'h3;
			goeSync_q <= 2'h0;
			clkPrev_q <= 1'b0;
			latPrev_q <= 1'b1;
		end
		else
		begin
			clkSync_q <= {clkSync_q[0], serClk};
			datSync_q <= {datSync_q[0], serData};
			latSync_q <= {latSync_q[0], serLatch};
			goeSync_q <= {goeSync_q[0], globalOutputEnablePin};
			clkPrev_q <= clkSync_q[1];
			latPrev_q <= latSync_q[1];
		end
	end

	wire clkRise   = clkSync_q[1] & ~clkPrev_q;
	wire latchRise = latSync_q[1] & ~latPrev_q;
	wire latchLow  = ~latSync_q[1];

	//----------------------------------------------------------------
	// shift register, msb first, counts bits of the frame
	//----------------------------------------------------------------
	reg  [`CCB_WORD_BITS-1:0] shift_q;
	reg  [5:0]                bitCnt_q;

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			shift_q  <= {`CCB_WORD_BITS{1'b0}};
			bitCnt_q <= 6'h00;
		end
		else if (latchRise)
			bitCnt_q <= 6'h00;
		else if (clkRise && latchLow)
		begin
			shift_q <= {shift_q[`CCB_WORD_BITS-2:0], datSync_q[1]};
			if (bitCnt_q != `CCB_CNT_MAX)
				bitCnt_q <= bitCnt_q + 6'h01;
		end
	end

	// only an exact 32-bit frame commits
	wire wordDone = latchRise && (bitCnt_q == `CCB_FRAME_CNT);
	wire [3:0] wAddr = shift_q[`CCB_ADDR_MSB:0];
	wire [`CCB_WORD_BITS-1:0] w = shift_q;
	wire softReset = wordDone && (wAddr == `CCB_ADDR_RESET) &&
		w[`CCB_RESET_BIT];
	wire loadDefaults = rst | softReset;

	//----------------------------------------------------------------
	// channel words
	//----------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch = ch + 1)
		begin : gCh
			wire hit = wordDone && ({28'h0000000, wAddr} == ch);
			// output state fields exist on channels one to three only
			wire hasState = (ch >= 1) && (ch <= 3);
			always @(posedge sys_clk)
			begin
				if (loadDefaults)
				begin
					channelSwingLevel[ch] <= `CCB_DEF_SWING;
					channelEnable[ch] <= (ch == 2) ?
						`CCB_DEF_EN_CH2 : `CCB_DEF_EN;
					secondOutputState[ch*2+1:ch*2] <= `CCB_DEF_BST;
					firstOutputState[ch*2+1:ch*2] <= hasState ?
						`CCB_DEF_AST : 2'h0;
				end
				else if (hit)
				begin
					channelSwingLevel[ch] <= w[`CCB_CH_SWING];
					channelEnable[ch] <= w[`CCB_CH_EN];
					if (hasState)
					begin
						secondOutputState[ch*2+1:ch*2] <=
							w[`CCB_CH_BST_MSB:`CCB_CH_BST_LSB];
						firstOutputState[ch*2+1:ch*2] <=
							w[`CCB_CH_AST_MSB:`CCB_CH_AST_LSB];
					end
				end
			end
			assign channelActive[ch] = channelEnable[ch] &
				allOutputsEnable & goeSync_q[1];
		end
	endgenerate

	//----------------------------------------------------------------
	// shared words
	//----------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (loadDefaults)
		begin
			tuningWaitForLock      <= `CCB_DEF_TUNE;
			refOneBufferType       <= `CCB_DEF_BUF;
			refZeroBufferType      <= `CCB_DEF_BUF;
			signalLossTimeout      <= `CCB_DEF_LOS_TO;
			signalLossOutputType   <= `CCB_DEF_LOS_TY;
			referenceSourceSelect  <= `CCB_DEF_SEL;
			firstLoopPumpPolarity  <= `CCB_DEF_L1_POL;
			firstLoopPumpGain      <= `CCB_DEF_L1_GAIN;
			firstLoopRefDivider    <= `CCB_DEF_DIV12;
			firstLoopFbDivider     <= `CCB_DEF_DIV12;
			referenceDoublerEnable <= `CCB_DEF_OFF;
			crystalSupportEnable   <= `CCB_DEF_OFF;
			oscOutputBufferEnable  <= `CCB_DEF_OFF;
			allOutputsEnable       <= `CCB_DEF_ALLEN;
			powerDown              <= `CCB_DEF_OFF;
			secondPumpHighZ        <= `CCB_DEF_OFF;
			firstPumpHighZ         <= `CCB_DEF_OFF;
			oscInputFrequency      <= `CCB_DEF_OSCF;
			lockDetectSelect       <= `CCB_DEF_LDSEL;
			secondLoopRefDivider   <= `CCB_DEF_DIV12;
			secondLoopFbDivider    <= `CCB_DEF_L2_N;
			secondLoopPumpGain     <= `CCB_DEF_L2_GAIN;
			oscOutputDivider       <= `CCB_DEF_VDIV;
		end
		else if (wordDone)
		begin
			case (wAddr)
				`CCB_ADDR_TUNE:
				begin
					tuningWaitForLock <= w[`CCB_TUNE_WAIT];
				end
				`CCB_ADDR_REFIN:
				begin
					refOneBufferType <= w[`CCB_REF1_BUF];
					refZeroBufferType <= w[`CCB_REF0_BUF];
					signalLossTimeout <=
						w[`CCB_LOS_TO_MSB:`CCB_LOS_TO_LSB];
					signalLossOutputType <=
						w[`CCB_LOS_TY_MSB:`CCB_LOS_TY_LSB];
					referenceSourceSelect <=
						w[`CCB_SEL_MSB:`CCB_SEL_LSB];
				end
				`CCB_ADDR_LOOP1:
				begin
					firstLoopPumpPolarity <= w[`CCB_L1_POL];
					firstLoopPumpGain <=
						w[`CCB_L1_GAIN_MSB:`CCB_L1_GAIN_LSB];
					firstLoopRefDivider <=
						w[`CCB_L1_R_MSB:`CCB_L1_R_LSB];
					firstLoopFbDivider <= w[`CCB_L1_N_MSB:`CCB_L1_N_LSB];
				end
				`CCB_ADDR_GLOBAL:
				begin
					crystalSupportEnable <= w[`CCB_G_XTAL];
					oscOutputBufferEnable <= w[`CCB_G_OSCBUF];
					allOutputsEnable <= w[`CCB_G_ALLEN];
					powerDown <= w[`CCB_G_PDN];
					referenceDoublerEnable <= w[`CCB_G_DOUBLER];
					secondPumpHighZ <= w[`CCB_G_HZ2];
					firstPumpHighZ <= w[`CCB_G_HZ1];
				end
				`CCB_ADDR_LOOP2R:
				begin
					oscInputFrequency <=
						w[`CCB_OSCF_MSB:`CCB_OSCF_LSB];
					lockDetectSelect <=
						w[`CCB_LDSEL_MSB:`CCB_LDSEL_LSB];
					secondLoopRefDivider <=
						w[`CCB_L2_R_MSB:`CCB_L2_R_LSB];
				end
				`CCB_ADDR_LOOP2N:
				begin
					secondLoopPumpGain <=
						w[`CCB_L2_GAIN_MSB:`CCB_L2_GAIN_LSB];
					oscOutputDivider <= w[`CCB_VDIV_MSB:`CCB_VDIV_LSB];
					secondLoopFbDivider <=
						w[`CCB_L2_N_MSB:`CCB_L2_N_LSB];
				end
				default:
				begin
					tuningWaitForLock <= tuningWaitForLock;
				end
			endcase
		end
	end

	//----------------------------------------------------------------
	// calibration start pulse
	//----------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (rst)
			calibrationStart <= 1'b0;
		else
			calibrationStart <= wordDone &&
				(wAddr == `CCB_ADDR_LOOP2N);
	end

endmodule
`default_nettype wire

/* File: tb/ccb_config_bank_props.sv */
// assertions on the configuration bank ports
`timescale 1ns/10ps
`default_nettype none
module ccb_config_bank_props
#(
	parameter NUM_CH = 5
)
(
	input wire logic                sys_clk,
	input wire logic                rst,
	input wire logic                serLatch,
	input wire logic                globalOutputEnablePin,
	input wire logic [NUM_CH-1:0]   channelEnable,
	input wire logic [NUM_CH-1:0]   channelActive,
	input wire logic [NUM_CH*2-1:0] firstOutputState,
	input wire logic [NUM_CH*2-1:0] secondOutputState,
	input wire logic                allOutputsEnable,
	input wire logic                powerDown,
	input wire logic [4:0]          lockDetectSelect,
	input wire logic [17:0]         secondLoopFbDivider,
	input wire logic                calibrationStart
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_global_gate: assert property (
		!allOutputsEnable |-> channelActive == '0)
		else $error("channel active while global enable off");
	a_active_subset: assert property (
		(channelActive & ~channelEnable) == '0)
		else $error("channel active without its enable");
	a_pin_low_off: assert property (
		!globalOutputEnablePin [*3] |-> channelActive == '0)
		else $error("channel active while enable pin low");
	a_pin_high_pass: assert property (
		globalOutputEnablePin [*3] |->
		channelActive == (channelEnable & {NUM_CH{allOutputsEnable}}))
		else $error("channel active differs from gated enables");
	a_reset_defaults: assert property (
		$fell(rst) |-> channelEnable == 5'h04 && !powerDown
		&& lockDetectSelect == 5'h1F)
		else $error("fields not at defaults after reset");
	a_cal_single: assert property (
		calibrationStart |=> !calibrationStart)
		else $error("calibration start longer than one cycle");
	a_hold_idle: assert property (
		!serLatch [*6] |=> $stable(channelEnable)
		&& $stable(secondLoopFbDivider) && !calibrationStart)
		else $error("fields changed while a word was shifting");
	a_edge_states: assert property (
		firstOutputState[1:0] == 2'h0 && secondOutputState[1:0] == 2'h0
		&& firstOutputState[NUM_CH*2-1 -: 2] == 2'h0
		&& secondOutputState[NUM_CH*2-1 -: 2] == 2'h0)
		else $error("outer channel output state not zero");
endmodule
bind ccb_config_bank ccb_config_bank_props #(.NUM_CH(NUM_CH)) u_props (
	.sys_clk               (sys_clk),
	.rst                   (rst),
	.serLatch              (serLatch),
	.globalOutputEnablePin (globalOutputEnablePin),
	.channelEnable         (channelEnable),
	.channelActive         (channelActive),
	.firstOutputState      (firstOutputState),
	.secondOutputState     (secondOutputState),
	.allOutputsEnable      (allOutputsEnable),
	.powerDown             (powerDown),
	.lockDetectSelect      (lockDetectSelect),
	.secondLoopFbDivider   (secondLoopFbDivider),
	.calibrationStart      (calibrationStart)
);
`default_nettype wire

/* File: tb/ccb_ser_host.sv */
// serial programming controller model driving the bank's load pins
`timescale 1ns/10ps
`default_nettype none
module ccb_ser_host
(
	input  wire logic sys_clk,
	output var logic  serClk,
	output var logic  serData,
	output var logic  serLatch
);
	initial
	begin
		serClk = 1'b0;
		serData = 1'b0;
		serLatch = 1'b1;
	end
	// n bits msb first; n other than 32 gives a broken frame
	task automatic sendWord(input logic [31:0] w, input int n);
		int i;
		@(negedge sys_clk);
		serLatch = 1'b0;
		// keep link edges off the system clock edges
		#0.25;
		for (i = n - 1; i >= 0; i--)
		begin
			serData = w[i % 32];
			#62.5 serClk = 1'b1;
			#62.5 serClk = 1'b0;
		end
		serData = ~serData;
		@(negedge sys_clk);
		serLatch = 1'b1;
		repeat (8) @(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

/* File: tb/ccb_config_bank_tb.sv */
// self-checking bench for the configuration bank
`timescale 1ns/10ps
`default_nettype none
module ccb_config_bank_tb;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        globalOutputEnablePin = 1'b1;
	int          err_total = 0;
	int          total_checks = 0;
	int          calCount = 0;
	wire         serClk, serData, serLatch;
	wire  [4:0]  channelSwingLevel, channelEnable, channelActive;
	wire  [9:0]  secondOutputState, firstOutputState;
	wire  [1:0]  signalLossTimeout, signalLossOutputType;
	wire  [1:0]  referenceSourceSelect, secondLoopPumpGain;
	wire  [2:0]  firstLoopPumpGain;
	wire  [11:0] firstLoopRefDivider, firstLoopFbDivider, secondLoopRefDivider;
	wire  [17:0] secondLoopFbDivider;
	wire  [7:0]  oscInputFrequency;
	wire  [4:0]  lockDetectSelect;
	wire  [3:0]  oscOutputDivider;
	wire         tuningWaitForLock, refOneBufferType, refZeroBufferType;
	wire         firstLoopPumpPolarity, referenceDoublerEnable, powerDown;
	wire         crystalSupportEnable, oscOutputBufferEnable, allOutputsEnable;
	wire         secondPumpHighZ, firstPumpHighZ, calibrationStart;
	wire  [29:0] chW = {channelSwingLevel, channelEnable, secondOutputState,
		firstOutputState};
	wire  [8:0]  refW = {tuningWaitForLock, refOneBufferType, refZeroBufferType,
		signalLossTimeout, signalLossOutputType, referenceSourceSelect};
	wire  [27:0] l1W = {firstLoopPumpPolarity, firstLoopPumpGain,
		firstLoopRefDivider, firstLoopFbDivider};
	wire  [6:0]  glW = {referenceDoublerEnable, crystalSupportEnable,
		oscOutputBufferEnable, allOutputsEnable, powerDown, secondPumpHighZ,
		firstPumpHighZ};
	wire  [48:0] l2W = {oscInputFrequency, lockDetectSelect, secondLoopRefDivider,
		secondLoopFbDivider, secondLoopPumpGain, oscOutputDivider};
	wire [122:0] allW = {chW, refW, l1W, glW, l2W};
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (calibrationStart === 1'b1) calCount <= calCount + 1;
	ccb_config_bank dut (.*);
	ccb_ser_host host (.*);
	task check(input logic [122:0] seen, input logic [122:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t seen %0h exp %0h", $time, seen, exp);
		end
	endtask
	task results;
		if (err_total == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chkDefaults;
		check(chW, {5'h00, 5'h04, 10'h000, 10'h054});
		check(refW, 9'h1DC);
		check(l1W, {1'b1, 3'h6, 12'h001, 12'h001});
		check(glW, 7'h08);
		check(l2W[48:36], {8'hC8, 5'h1F});
		check(l2W[35:0], {12'h001, 18'h1, 2'h2, 4'h2});
	endtask
	task tChannels;
		int k;
		logic [3:0] st;
		for (k = 0; k < 5; k++)
		begin
			host.sendWord((k == 2 ? 32'h00DC_0000 : 32'h00DD_0000) | k, 32);
			st = {secondOutputState[2*k+:2], firstOutputState[2*k+:2]};
			check({channelSwingLevel[k], channelEnable[k]}, {1'b1, k != 2});
			check(st, (k > 0 && k < 4) ? 4'hB : 4'h0);
		end
		check(channelActive, 5'h1B);
		@(negedge sys_clk) globalOutputEnablePin = 1'b0;
		repeat (4) @(negedge sys_clk);
		check(channelActive, 5'h00);
		globalOutputEnablePin = 1'b1;
		repeat (4) @(negedge sys_clk);
	endtask
	task tWords;
		host.sendWord(32'h0000_000A, 32);
		check(tuningWaitForLock, 1'b0);
		host.sendWord(32'h0000_063B, 32);
		check(refW[7:0], 8'h63);
		host.sendWord(32'h3ABC_123C, 32);
		check(l1W, 28'h3ABC123);
		host.sendWord(32'h0033_C00D, 32);
		check(glW, 7'h77);
		check(channelActive, 5'h00);
		host.sendWord(32'h0C85_321E, 32);
		check(l2W[48:24], {8'h64, 5'h05, 12'h321});
		check(calCount, 0);
		host.sendWord(32'h056A_BCDF, 32);
		check(l2W, {8'h64, 5'h05, 12'h321, 18'h2ABCD, 2'h1, 4'h5});
		check(calCount, 1);
	endtask
	task tFrames;
		logic [122:0] snap;
		snap = allW;
		host.sendWord(32'h0000_000D, 31);
		host.sendWord(32'h0000_000D, 33);
		host.sendWord(32'hFFFF_FFE5, 32);
		host.sendWord(32'hFFFF_FFE7, 32);
		check(allW, snap);
		host.sendWord(32'hFFFF_FFF7, 32);
		chkDefaults();
	endtask
	task tReset;
		host.sendWord(32'h0033_C00D, 32);
		@(negedge sys_clk) rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		chkDefaults();
	endtask
	initial
	begin
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		chkDefaults();
		tChannels();
		tWords();
		tFrames();
		tReset();
		results();
	end
	initial
	begin
		#400000;
		err_total++;
		results();
	end
endmodule
`default_nettype wire
